//--- shared/lcdc_pkg.sv
// Package for the dot matrix display controller register front end
package lcdc_pkg;
  localparam int LCDC_DW = 8;
  localparam logic [7:0] LCDC_INDEX_RST = 8'h00;
  localparam logic [7:0] LCDC_CONFIG_RST = 8'h00;
  localparam logic [7:0] LCDC_CONTROL_RST = 8'h00;
  // Index codes of the control registers
  localparam logic [3:0] LCDC_IDX_CONFIG = 4'h0;
  localparam logic [3:0] LCDC_IDX_CONTROL = 4'h1;
  localparam logic [3:0] LCDC_IDX_ADDRESS = 4'h2;
  localparam logic [3:0] LCDC_IDX_FRAME = 4'h3;
  localparam logic [3:0] LCDC_IDX_DATA = 4'h4;
  localparam logic [3:0] LCDC_IDX_START = 4'h5;
  localparam logic [3:0] LCDC_IDX_BLINK = 4'h6;
  localparam logic [3:0] LCDC_IDX_BSTART = 4'h8;
  localparam logic [3:0] LCDC_IDX_BEND = 4'h9;
  localparam logic [3:0] LCDC_IDX_CONTRAST = 4'ha;
  // Config register field positions
  localparam int LCDC_CFG_STANDBY = 5;
  localparam int LCDC_CFG_STEPUP = 4;
  localparam int LCDC_CFG_GRAPHIC = 2;
  localparam int LCDC_CFG_DUTY_HI = 1;
  localparam int LCDC_CFG_DUTY_LO = 0;
  // Control register field positions
  localparam int LCDC_CTL_DISPLAY = 6;
  localparam int LCDC_CTL_AMP = 4;
  // Geometry limits
  localparam logic [2:0] LCDC_XMAX_32 = 3'h4;
  localparam logic [2:0] LCDC_XMAX_16 = 3'h6;
  localparam logic [2:0] LCDC_XMAX_8 = 3'h7;
  localparam logic [4:0] LCDC_YMAX_32 = 5'h1f;
  localparam logic [4:0] LCDC_YMAX_16 = 5'h0f;
  localparam logic [4:0] LCDC_YMAX_8 = 5'h07;
  localparam int LCDC_MAX_BITS = 1280;
  // Dots per byte in character mode
  localparam int LCDC_CHAR_BITS = 5;
  typedef enum logic [1:0] {LCDC_DUTY32 = 2'b00, LCDC_DUTY16 = 2'b01, LCDC_DUTY8 = 2'b10} lcdc_duty_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [7:0] data;
  } lcdc_host_type;
  typedef struct packed {
    logic standby;
    logic stepup;
    logic graphic;
    lcdc_duty_type duty;
  } lcdc_cfg_type;
  function automatic lcdc_duty_type lcdc_duty(input logic [1:0] f);
    return f[1] ? LCDC_DUTY8 : (f[0] ? LCDC_DUTY16 : LCDC_DUTY32);
  endfunction
  function automatic logic [2:0] lcdc_xmax(input lcdc_duty_type d);
    return d == LCDC_DUTY8 ? LCDC_XMAX_8 : (d == LCDC_DUTY16 ? LCDC_XMAX_16 : LCDC_XMAX_32);
  endfunction
  function automatic logic [4:0] lcdc_ymax(input lcdc_duty_type d);
    return d == LCDC_DUTY8 ? LCDC_YMAX_8 : (d == LCDC_DUTY16 ? LCDC_YMAX_16 : LCDC_YMAX_32);
  endfunction
  function automatic logic lcdc_valid(input logic [3:0] i);
    return (i <= LCDC_IDX_BLINK) || (i == LCDC_IDX_BSTART) || (i == LCDC_IDX_BEND) || (i == LCDC_IDX_CONTRAST);
  endfunction
endpackage

//--- hdl/lcdc_mem.sv
// Display memory, 8 by 32 bytes, registered read port
`timescale 1ns/10ps
module lcdc_mem
  import lcdc_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 8
) (
  // Clock
  input wire logic i_clock,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;
  // No reset on storage: contents are undefined until written
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    rdata_q <= mem_q[i_raddr];
  end
  assign o_rdata = rdata_q;
endmodule // lcdc_mem

//--- hdl/lcdc_regs.sv
// Register front end and first configuration register of the dot matrix display controller
// Behaviour
// - Write with select line low loads the index pointer, never a control register.
// - Low four index bits pick one of ten control registers; other codes invalid.
// - Only the display data register returns read data; all others write-only.
// - Reset clears the index pointer to zero.
// - Reset clears the config register: normal, step-up off, character, 1/32 duty.
// - Standby halts operation, blanks display, clears display-on and amp enable.
// - Config bit 4 enables the step-up circuit; cleared after reset.
// - Character mode shows five low bits per byte; graphic mode all eight.
// - Graphic mode limits shown byte column to 4, 6 or 7 by duty.
// - Duty 00 is 1/32, 01 is 1/16, 1x is 1/8.
// - Rows 10h-1Fh hidden at 1/16 duty, rows 8h-1Fh at 1/8 duty.
// - Each shown display memory bit drives exactly one dot.
// - Arrangements up to 40x32 dots, never above 1280 active bits.
// - Logic runs on the low-rate subclock only.
// - Display off drives all common and segment outputs to ground.
`timescale 1ns/10ps
module lcdc_regs
  import lcdc_pkg::*;
#(
  parameter int NCOM = 32,
  parameter int NSEG = 64
) (
  // Clock and reset; the clock is the subclock
  input wire logic i_clock,
  input wire logic i_rstn,
  // Host port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_register_select_line,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Scan position from the timing generator
  input wire logic [4:0] i_scan_row,
  // Panel drive
  output logic [NCOM-1:0] o_common_drive_outputs,
  output logic [NSEG-1:0] o_segment_drive_outputs,
  output logic o_stepup_run,
  output logic o_amp_run,
  output logic o_standby
);
  lcdc_host_type host;
  logic [3:0] index_pointer_q, index_pointer_d;
  lcdc_cfg_type display_config_q, display_config_d;
  logic display_on_q, display_on_d;
  logic amp_en_q, amp_en_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d, rpend_q, rpend_d;
  logic [NCOM-1:0] com_q, com_d;
  logic [NSEG-1:0] seg_q, seg_d;
  logic [2:0] col_q, col_d;
  logic [6:0] seg_lim;
  logic stepup_run_q, stepup_run_d;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic ctl_wr;

  assign host = '{wr: i_wr, rd: i_rd, sel: i_register_select_line, data: i_wdata};
  assign ctl_wr = host.wr && host.sel && lcdc_valid(index_pointer_q);
  assign mem_we = ctl_wr && index_pointer_q == LCDC_IDX_DATA;

  lcdc_mem #(.DW(8), .AW(8)) u_mem (
    .i_clock(i_clock),
    .i_we(mem_we),
    .i_waddr(addr_q),
    .i_wdata(host.data),
    .i_raddr(rpend_d ? addr_q : {col_d, i_scan_row}),
    .o_rdata(mem_rdata)
  );

  always_comb begin
    index_pointer_d = index_pointer_q;
    display_config_d = display_config_q;
    display_on_d = display_on_q;
    amp_en_d = amp_en_q;
    addr_d = addr_q;
    if (host.wr && !host.sel) begin
      index_pointer_d = host.data[3:0];
    end else if (ctl_wr) begin
      case (index_pointer_q)
        LCDC_IDX_CONFIG: begin
          display_config_d.standby = host.data[LCDC_CFG_STANDBY];
          display_config_d.stepup = host.data[LCDC_CFG_STEPUP];
          display_config_d.graphic = host.data[LCDC_CFG_GRAPHIC];
          display_config_d.duty = lcdc_duty(host.data[LCDC_CFG_DUTY_HI:LCDC_CFG_DUTY_LO]);
        end
        LCDC_IDX_CONTROL: begin
          display_on_d = host.data[LCDC_CTL_DISPLAY];
          amp_en_d = host.data[LCDC_CTL_AMP];
        end
        LCDC_IDX_ADDRESS: begin
          addr_d = host.data;
        end
        default: begin
        end
      endcase
    end
    if (display_config_d.standby) begin
      display_on_d = 1'b0;
      amp_en_d = 1'b0;
    end
    stepup_run_d = display_config_d.stepup && !display_config_d.standby;
  end

  always_comb begin
    rpend_d = host.rd && host.sel && index_pointer_q == LCDC_IDX_DATA;
    rvalid_d = rpend_q;
    rdata_d = rpend_q ? mem_rdata : 8'h00;
  end

  // Scan: one byte column per cycle; the read address runs one column ahead to cover memory latency
  always_comb begin
    col_d = col_q + 3'h1;
    if (display_config_q.graphic && col_q >= lcdc_xmax(display_config_q.duty)) begin
      col_d = 3'h0;
    end
    // Character mode packs five dots per byte, so eight bytes fill forty segments
    seg_lim = 7'(LCDC_CHAR_BITS * 8);
    if (display_config_q.graphic) begin
      seg_lim = 7'((32'(lcdc_xmax(display_config_q.duty)) + 1) * 8);
    end
    com_d = '0;
    seg_d = seg_q;
    if (!display_on_q || display_config_q.standby) begin
      seg_d = '0;
    end else if (i_scan_row <= lcdc_ymax(display_config_q.duty)) begin
      com_d[i_scan_row] = 1'b1;
      if (!rpend_q) begin
        for (int b = 0; b < 8; b++) begin
          if (display_config_q.graphic) begin
            seg_d[{col_q, 3'h0} + 6'(b)] = mem_rdata[b];
          end else if (b < LCDC_CHAR_BITS) begin
            seg_d[6'(32'(col_q) * LCDC_CHAR_BITS + b)] = mem_rdata[b];
          end
        end
      end
    end else begin
      seg_d = '0;
    end
    // Segments past the active width are cleared so stale dots of another mode never show
    for (int s = 0; s < NSEG; s++) begin
      if (s >= int'(seg_lim)) begin
        seg_d[s] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      index_pointer_q <= LCDC_INDEX_RST[3:0];
      display_config_q <= lcdc_cfg_type'(LCDC_CONFIG_RST[4:0]);
      display_on_q <= 1'b0;
      amp_en_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      rpend_q <= 1'b0;
      com_q <= '0;
      seg_q <= '0;
      col_q <= 3'h0;
      stepup_run_q <= 1'b0;
    end else begin
      index_pointer_q <= index_pointer_d;
      display_config_q <= display_config_d;
      display_on_q <= display_on_d;
      amp_en_q <= amp_en_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      rpend_q <= rpend_d;
      com_q <= com_d;
      seg_q <= seg_d;
      col_q <= col_d;
      stepup_run_q <= stepup_run_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_common_drive_outputs = com_q;
  assign o_segment_drive_outputs = seg_q;
  assign o_stepup_run = stepup_run_q;
  assign o_amp_run = amp_en_q;
  assign o_standby = display_config_q.standby;

  property p_index_load;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_wr && !i_register_select_line) |=> (index_pointer_q == $past(i_wdata[3:0]));
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not loaded");

  property p_index_no_cfg;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_wr && !i_register_select_line) |=> $stable(display_config_q);
  endproperty
  a_index_no_cfg: assert property (p_index_no_cfg) else $error("config changed by index write");

  property p_invalid;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_wr && i_register_select_line && !lcdc_valid(index_pointer_q)) |=> $stable(display_config_q) && $stable(addr_q);
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid index wrote");

  property p_read_only_data;
    @(posedge i_clock) disable iff (!i_rstn)
    o_rvalid |-> $past(i_rd && i_register_select_line && index_pointer_q == LCDC_IDX_DATA, 2);
  endproperty
  a_read_only_data: assert property (p_read_only_data) else $error("read from write-only reg");

  property p_reset;
    @(posedge i_clock) !i_rstn |=> index_pointer_q == 4'h0 && display_config_q == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  property p_standby;
    @(posedge i_clock) disable iff (!i_rstn)
    display_config_q.standby |-> !display_on_q && !amp_en_q && !o_stepup_run;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not honoured");

  property p_off_ground;
    @(posedge i_clock) disable iff (!i_rstn)
    !display_on_q ##1 !display_on_q |-> o_common_drive_outputs == '0 && o_segment_drive_outputs == '0;
  endproperty
  a_off_ground: assert property (p_off_ground) else $error("panel driven while off");

  property p_char_mode;
    @(posedge i_clock) disable iff (!i_rstn)
    !display_config_q.graphic |=> o_segment_drive_outputs[NSEG-1:LCDC_CHAR_BITS*8] == '0;
  endproperty
  a_char_mode: assert property (p_char_mode) else $error("character mode leaks bits");

  property p_col_limit;
    @(posedge i_clock) disable iff (!i_rstn)
    display_config_q.graphic && $stable(display_config_q) |-> col_q <= lcdc_xmax(display_config_q.duty);
  endproperty
  a_col_limit: assert property (p_col_limit) else $error("column beyond duty limit");

  property p_row_hidden;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_scan_row > lcdc_ymax(display_config_q.duty)) |=> o_common_drive_outputs == '0;
  endproperty
  a_row_hidden: assert property (p_row_hidden) else $error("hidden row shown");
endmodule // lcdc_regs

//--- sim/lcdc_host.sv
// Host processor model driving the controller port lines
`timescale 1ns/10ps
module lcdc_host (
  // Clock
  input wire logic i_clock,
  // Port lines
  output logic o_wr,
  output logic o_rd,
  output logic o_sel,
  output logic [7:0] o_wdata,
  // Read answer
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_sel = 1'b0;
    o_wdata = 8'h00;
  end
  // Released lines flip to the inverse so a stale value never looks valid
  task automatic put(input logic sel, input logic [7:0] data);
    @(negedge i_clock);
    o_wr = 1'b1;
    o_sel = sel;
    o_wdata = data;
    @(negedge i_clock);
    o_wr = 1'b0;
    o_sel = ~sel;
    o_wdata = ~data;
  endtask
  // Answer stands between the first and second edge after the taking edge
  task automatic get(input logic sel, output logic [7:0] data, output logic ok);
    @(negedge i_clock);
    o_rd = 1'b1;
    o_sel = sel;
    @(negedge i_clock);
    o_rd = 1'b0;
    o_sel = ~sel;
    @(negedge i_clock);
    data = i_rdata;
    ok = i_rvalid;
  endtask
endmodule // lcdc_host

//--- sim/testbench.sv
// Self-checking testbench for the display controller front end
`timescale 1ns/10ps
module testbench;
  import lcdc_pkg::*;
  logic i_clock;
  logic i_rstn;
  logic [4:0] i_scan_row;
  logic wr, rd, sel, rvalid, stepup_run, amp_run, standby;
  logic [7:0] wdata, rdata;
  logic [31:0] com;
  logic [63:0] seg;
  int error_cnt = 0;
  int checks_done = 0;
  lcdc_regs #(.NCOM(32), .NSEG(64)) lcdc_regs_inst (.i_clock(i_clock), .i_rstn(i_rstn), .i_wr(wr),
    .i_rd(rd), .i_register_select_line(sel), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_scan_row(i_scan_row), .o_common_drive_outputs(com), .o_segment_drive_outputs(seg),
    .o_stepup_run(stepup_run), .o_amp_run(amp_run), .o_standby(standby));
  lcdc_host lcdc_host_inst (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_sel(sel), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic reg_wr(input logic [3:0] idx, input logic [7:0] data);
    lcdc_host_inst.put(1'b0, {4'h0, idx});
    lcdc_host_inst.put(1'b1, data);
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clock);
    #1;
  endtask
  task automatic t_config();
    reg_wr(LCDC_IDX_CONFIG, 8'h10);
    lcdc_host_inst.put(1'b0, 8'h01);
    settle();
    chk({standby, stepup_run}, 64'h1, "step-up on");
    lcdc_host_inst.put(1'b1, 8'h50);
    settle();
    chk(amp_run, 64'h1, "amp on");
  endtask
  task automatic t_standby();
    reg_wr(LCDC_IDX_CONFIG, 8'h30);
    settle();
    chk({standby, stepup_run, amp_run}, 64'h4, "standby");
    lcdc_host_inst.put(1'b1, 8'h10);
    settle();
    chk({standby, stepup_run, amp_run}, 64'h2, "leave standby");
  endtask
  task automatic t_invalid();
    logic [3:0] bad [6] = '{4'h7, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    foreach (bad[i]) reg_wr(bad[i], 8'h30);
    settle();
    chk({standby, stepup_run, amp_run}, 64'h2, "invalid index");
  endtask
  task automatic t_memory();
    logic [7:0] q;
    logic ok;
    reg_wr(LCDC_IDX_ADDRESS, 8'h23);
    reg_wr(LCDC_IDX_DATA, 8'ha5);
    lcdc_host_inst.get(1'b1, q, ok);
    chk({ok, q}, 64'h1a5, "data read");
    reg_wr(LCDC_IDX_CONTROL, 8'h40);
    lcdc_host_inst.get(1'b1, q, ok);
    chk({ok, q}, 64'h0, "write-only read");
    lcdc_host_inst.get(1'b0, q, ok);
    chk({ok, q}, 64'h0, "index read");
  endtask
  // Byte at column 1, row 3 was loaded by the memory scenario
  task automatic t_graphic();
    reg_wr(LCDC_IDX_CONFIG, 8'h14);
    @(negedge i_clock);
    i_scan_row = 5'h03;
    repeat (12) @(negedge i_clock);
    chk(seg[15:8], 64'ha5, "graphic byte");
    chk({com, seg[63:40]}, 64'h8000000, "graphic width");
    reg_wr(LCDC_IDX_CONFIG, 8'h10);
    repeat (12) @(negedge i_clock);
    chk({seg[63:40], seg[9:5]}, 64'h5, "character byte");
  endtask
  // Rows just past the 1/16 and 1/8 limits must stay dark; rows at each limit stay lit
  task automatic t_duty();
    logic [7:0] cfg [6] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h03};
    logic [4:0] row [6] = '{5'h1f, 5'h10, 5'h0f, 5'h08, 5'h08, 5'h07};
    logic [31:0] exp [6] = '{32'h80000000, 32'h0, 32'h8000, 32'h0, 32'h0, 32'h80};
    foreach (cfg[i]) begin
      reg_wr(LCDC_IDX_CONFIG, cfg[i]);
      @(negedge i_clock);
      i_scan_row = row[i];
      settle();
      chk(com, exp[i], "common at duty");
    end
    reg_wr(LCDC_IDX_CONTROL, 8'h00);
    settle();
    chk(com, 64'h0, "common off");
    chk(seg, 64'h0, "segment off");
  endtask
  initial begin
    i_rstn = 1'b0;
    i_scan_row = 5'h00;
    repeat (8) @(negedge i_clock);
    i_rstn = 1'b1;
    chk({standby, stepup_run, amp_run, rvalid}, 64'h0, "reset flags");
    chk(com, 64'h0, "reset common");
    t_config();
    t_standby();
    t_invalid();
    t_memory();
    t_graphic();
    t_duty();
    give_verdict();
  end
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end
endmodule // testbench
